// ### core/psc_power_saving_control.sv
// Power-saving control: slow-discharge wake, sleep regulator choice, doze divider.
`timescale 1ns/1ps
module psc_power_saving_control #(
    parameter int STANDBY_WAKE_CYC = psc_pkg::WAKE_STANDBY_CYC,
    parameter int LV_WAKE_CYC = psc_pkg::WAKE_LV_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [psc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    input wire logic lvRegulatorConfig,
    input wire logic sleepCmd,
    input wire logic deepSleepCmd,
    input wire logic idleMode,
    input wire logic wakePinIn,
    input wire logic cpuIrqReq,
    output logic wakeSinkOn,
    output logic sleeping,
    output logic cpuResume,
    output logic cpuClkEn,
    output logic periphClkEn,
    output logic hvRegNormal,
    output logic hvRegStandby,
    output logic lvRegOn,
    output logic irqOut
);
    psc_pkg::psc_state_s s_r;
    psc_pkg::psc_state_s s_nxt;

    // Ratio N = 2^code, expressed as a terminal count of N-1.
    function automatic logic [7:0] dozeLimit(input logic [2:0] code);
        dozeLimit = 8'((9'h001 << code) - 9'h001);
    endfunction : dozeLimit

    // Regulator modes during Sleep from config, enable and sleep mode bits.
    function automatic psc_pkg::psc_reg_s sleepReg(input logic cfg,
                                                    input logic lv_regulator_enable,
                                                    input logic sleep_regulator_mode);
        sleepReg.hvNormal = sleep_regulator_mode;
        sleepReg.hvStandby = !sleep_regulator_mode && (cfg || !lv_regulator_enable);
        sleepReg.lvOn = !cfg && lv_regulator_enable && !sleep_regulator_mode;
    endfunction : sleepReg

    logic wakeLow;
    logic modEn;
    logic active;
    logic [7:0] lim;
    logic irqSeen;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pin1 = wakePinIn;
        s_nxt.pin2 = s_r.pin1;
        s_nxt.irq1 = cpuIrqReq;
        s_nxt.irq2 = s_r.irq1;
        s_nxt.wakeEvt = 1'b0;
        wakeLow = !s_r.pin2;
        irqSeen = s_r.irq2;
        modEn = s_r.wakeCon[psc_pkg::WK_EN_BIT];
        active = modEn && !(idleMode && s_r.wakeCon[psc_pkg::WK_IDL_BIT]);
        // The sink runs only while the module is on; software owns the charge phase.
        s_nxt.sinkOn = active && s_r.wakeCon[psc_pkg::WK_SINK_BIT];

        // Sleep sequencing.
        case (s_r.state)
            psc_pkg::PSC_RUN: begin
                s_nxt.regCtl = '{hvNormal: 1'b1, hvStandby: 1'b0,
                                 lvOn: 1'b0};
                if (deepSleepCmd) begin
                    s_nxt.state = psc_pkg::PSC_DEEP;
                end else if (sleepCmd) begin
                    s_nxt.state = psc_pkg::PSC_SLEEP;
                    s_nxt.regCtl = sleepReg(lvRegulatorConfig,
                        s_r.pwrCtl[psc_pkg::LV_REGULATOR_ENABLE_BIT],
                        s_r.pwrCtl[psc_pkg::SLEEP_REGULATOR_MODE_BIT]);
                end
            end
            psc_pkg::PSC_SLEEP: begin
                if (active && wakeLow) begin
                    s_nxt.wakeEvt = 1'b1;
                    s_nxt.state = psc_pkg::PSC_WAKING;
                    s_nxt.lvSlept = s_r.regCtl.lvOn;
                    // Low-voltage sleep must ramp the core rail back up first.
                    if (s_r.regCtl.lvOn) begin
                        s_nxt.wakeCnt = 8'(LV_WAKE_CYC);
                    end else if (s_r.regCtl.hvStandby) begin
                        s_nxt.wakeCnt = 8'(STANDBY_WAKE_CYC);
                    end else begin
                        s_nxt.wakeCnt = psc_pkg::CNT_ONE;
                    end
                    s_nxt.regCtl = '{hvNormal: 1'b1, hvStandby: 1'b0,
                                     lvOn: 1'b0};
                end
            end
            psc_pkg::PSC_WAKING: begin
                if (s_r.wakeCnt <= psc_pkg::CNT_ONE) begin
                    s_nxt.state = psc_pkg::PSC_RUN;
                    s_nxt.wakeCnt = '0;
                end else begin
                    s_nxt.wakeCnt = s_r.wakeCnt - psc_pkg::CNT_ONE;
                end
            end
            psc_pkg::PSC_DEEP: begin
                s_nxt.regCtl = '{hvNormal: 1'b0, hvStandby: 1'b0,
                                 lvOn: 1'b0};
            end
            default: s_nxt.state = psc_pkg::PSC_RUN;
        endcase

        // Doze divider on the single system clock.
        if (s_r.clock_divider_reg[psc_pkg::ROI_BIT] && irqSeen && s_r.dozeOn) begin
            s_nxt.clock_divider_reg[psc_pkg::DOZE_ENABLE_BIT] = 1'b0;
        end
        s_nxt.dozeOn = s_nxt.clock_divider_reg[psc_pkg::DOZE_ENABLE_BIT];
        lim = s_r.dozeOn ?
            dozeLimit(s_r.clock_divider_reg[psc_pkg::DOZE_HI:psc_pkg::DOZE_LO]) : '0;
        // Judged on the next state so the enable drops in the first Sleep cycle.
        if (s_nxt.state != psc_pkg::PSC_RUN) begin
            s_nxt.cpuEn = 1'b0;
            s_nxt.dozeCnt = '0;
        end else if (s_r.dozeCnt >= lim) begin
            s_nxt.cpuEn = 1'b1;
            s_nxt.dozeCnt = '0;
        end else begin
            s_nxt.cpuEn = 1'b0;
            s_nxt.dozeCnt = s_r.dozeCnt + psc_pkg::CNT_ONE;
        end

        // Register writes; the hardware set of the flag wins over a clear.
        s_nxt.rdData = '0;
        if (regWrStb) begin
            if (regAddr == psc_pkg::OFF_WAKECON) begin
                s_nxt.wakeCon = regWrData & psc_pkg::WAKECON_MASK;
            end else if (regAddr == psc_pkg::OFF_CLOCK_DIVIDER_REG) begin
                s_nxt.clock_divider_reg = regWrData & psc_pkg::CLOCK_DIVIDER_REG_MASK;
                s_nxt.dozeOn = regWrData[psc_pkg::DOZE_ENABLE_BIT];
            end else if (regAddr == psc_pkg::OFF_PWRCTL) begin
                s_nxt.pwrCtl = regWrData & psc_pkg::PWRCTL_MASK;
            end else if (regAddr == psc_pkg::OFF_IRQSTAT) begin
                s_nxt.irqStat = s_r.irqStat & ~regWrData;
            end else if (regAddr == psc_pkg::OFF_IRQMASK) begin
                s_nxt.irqMask = regWrData & psc_pkg::IRQ_MASK;
            end
        end
        if (s_r.wakeEvt) begin
            s_nxt.irqStat[psc_pkg::WAKE_IF_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);

        if (regRdStb) begin
            if (regAddr == psc_pkg::OFF_WAKECON) begin
                s_nxt.rdData = s_r.wakeCon;
            end else if (regAddr == psc_pkg::OFF_CLOCK_DIVIDER_REG) begin
                s_nxt.rdData = s_r.clock_divider_reg;
            end else if (regAddr == psc_pkg::OFF_PWRCTL) begin
                s_nxt.rdData = s_r.pwrCtl;
            end else if (regAddr == psc_pkg::OFF_IRQSTAT) begin
                s_nxt.rdData = s_r.irqStat;
            end else if (regAddr == psc_pkg::OFF_IRQMASK) begin
                s_nxt.rdData = s_r.irqMask;
            end else if (regAddr == psc_pkg::OFF_REGSTAT) begin
                s_nxt.rdData = {10'h000, s_r.lvSlept, s_r.regCtl,
                                s_r.state};
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.state <= psc_pkg::PSC_RUN;
            s_r.regCtl <= '{hvNormal: 1'b1, hvStandby: 1'b0, lvOn: 1'b0};
            s_r.clock_divider_reg <= psc_pkg::RESET_ZERO;
            s_r.pin1 <= 1'b1;
            s_r.pin2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign regRdData = s_r.rdData;
    assign wakeSinkOn = s_r.sinkOn;
    assign sleeping = (s_r.state == psc_pkg::PSC_SLEEP);
    assign cpuResume = s_r.wakeEvt;
    assign cpuClkEn = s_r.cpuEn;
    assign periphClkEn = 1'b1;
    assign hvRegNormal = s_r.regCtl.hvNormal;
    assign hvRegStandby = s_r.regCtl.hvStandby;
    assign lvRegOn = s_r.regCtl.lvOn;
    assign irqOut = s_r.irq;
endmodule : psc_power_saving_control

// ### core/psc_pkg.sv
// Package of register map, field layout, states and timing of the power-saving control.
package psc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_WAKECON = 4'h0;
    localparam logic [3:0] OFF_CLOCK_DIVIDER_REG = 4'h1;
    localparam logic [3:0] OFF_PWRCTL = 4'h2;
    localparam logic [3:0] OFF_IRQSTAT = 4'h3;
    localparam logic [3:0] OFF_IRQMASK = 4'h4;
    localparam logic [3:0] OFF_REGSTAT = 4'h5;
    localparam int WK_EN_BIT = 15;
    localparam int WK_IDL_BIT = 13;
    localparam int WK_SINK_BIT = 8;
    localparam logic [15:0] WAKECON_MASK = 16'hA100;
    localparam int ROI_BIT = 15;
    localparam int DOZE_HI = 14;
    localparam int DOZE_LO = 12;
    localparam int DOZE_ENABLE_BIT = 11;
    localparam logic [15:0] CLOCK_DIVIDER_REG_MASK = 16'hF800;
    localparam int LV_REGULATOR_ENABLE_BIT = 12;
    localparam int SLEEP_REGULATOR_MODE_BIT = 8;
    localparam logic [15:0] PWRCTL_MASK = 16'h1100;
    localparam int WAKE_IF_BIT = 0;
    localparam logic [15:0] IRQ_MASK = 16'h0001;
    localparam logic [15:0] RESET_ZERO = 16'h0000;
    localparam logic [2:0] DOZE_DEFAULT = 3'h0;
    localparam int WAKE_STANDBY_NS = 2000;
    localparam int WAKE_LV_NS = 10000;
    localparam int CLK_NS = 50;
    localparam int WAKE_STANDBY_CYC = (WAKE_STANDBY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_LV_CYC = (WAKE_LV_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        PSC_RUN = 2'b00,
        PSC_SLEEP = 2'b01,
        PSC_WAKING = 2'b10,
        PSC_DEEP = 2'b11
    } psc_state_e;

    typedef struct packed {
        logic hvNormal;
        logic hvStandby;
        logic lvOn;
    } psc_reg_s;

    typedef struct packed {
        psc_state_e state;
        logic [15:0] wakeCon;
        logic [15:0] clock_divider_reg;
        logic [15:0] pwrCtl;
        logic [15:0] irqStat;
        logic [15:0] irqMask;
        logic [15:0] rdData;
        logic [7:0] wakeCnt;
        logic [7:0] dozeCnt;
        logic dozeOn;
        logic cpuEn;
        logic sinkOn;
        logic irq;
        logic wakeEvt;
        logic lvSlept;
        psc_reg_s regCtl;
        logic pin1;
        logic pin2;
        logic irq1;
        logic irq2;
    } psc_state_s;
endpackage : psc_pkg

// ### verification/psc_assertions.sv
// Checker of the power-saving control's port behaviour.
`timescale 1ns/1ps
module psc_assertions #(
    parameter int STANDBY_WAKE_CYC = 4,
    parameter int LV_WAKE_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [psc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic lvRegulatorConfig,
    input wire logic sleepCmd,
    input wire logic deepSleepCmd,
    input wire logic idleMode,
    input wire logic wakePinIn,
    input wire logic cpuIrqReq,
    input wire logic wakeSinkOn,
    input wire logic sleeping,
    input wire logic cpuResume,
    input wire logic cpuClkEn,
    input wire logic periphClkEn,
    input wire logic hvRegNormal,
    input wire logic hvRegStandby,
    input wire logic lvRegOn,
    input wire logic irqOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    periph_full_a: assert property (periphClkEn == 1'b1)
        else $error("peripheral clock enable dropped");
    rd_idle_a: assert property (!regRdStb |=> regRdData == 16'h0000)
        else $error("read data outside the answer cycle");
    resume_cause_a: assert property (cpuResume |-> $past(sleeping) && !$past(wakePinIn))
        else $error("resume without sleep and low pin");
    resume_exit_a: assert property (cpuResume |=> !sleeping && !cpuResume)
        else $error("resume did not leave sleep");
    lv_cfg_off_a: assert property (lvRegulatorConfig && $past(lvRegulatorConfig) |-> !lvRegOn)
        else $error("low-voltage regulator on against config");
    hv_excl_a: assert property (!(hvRegNormal && hvRegStandby))
        else $error("main regulator normal and standby at once");
    lv_sleep_a: assert property (sleeping && lvRegOn |-> !hvRegNormal && !hvRegStandby)
        else $error("main regulator on in low-voltage sleep");
    deep_off_a: assert property (deepSleepCmd |-> ##[1:3] !hvRegNormal && !hvRegStandby && !lvRegOn)
        else $error("regulators still on in deep sleep");
    sleep_cpu_a: assert property (sleeping |-> !cpuClkEn)
        else $error("cpu clock enabled in sleep");
    wake_c: cover property (cpuResume);
    lv_sleep_c: cover property (sleeping && lvRegOn);
    doze_c: cover property (cpuClkEn ##1 !cpuClkEn);
endmodule : psc_assertions

// ### verification/psc_rc_model.sv
// Resistor-capacitor network on the wake pin.
`timescale 1ns/1ps
module psc_rc_model #(
    parameter int DISCH_CYC = 16
) (
    input wire logic sys_clk,
    input wire logic chargeCmd,
    input wire logic sinkOn,
    output logic wakePin
);
    int charge_r = 0;
    always @(posedge sys_clk) begin
        if (chargeCmd) begin
            charge_r <= DISCH_CYC;
        end else if (sinkOn && charge_r > 0) begin
            charge_r <= charge_r - 1;
        end
    end
    // The pin reads low once the capacitor has drained below the low level.
    assign wakePin = charge_r > 0;
endmodule : psc_rc_model

// ### verification/tb_top.sv
// Self-checking testbench of the power-saving control.
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrStb = 1'b0, regRdStb = 1'b0, lvRegulatorConfig = 1'b0;
    logic sleepCmd = 1'b0, deepSleepCmd = 1'b0, cpuIrqReq = 1'b0;
    logic chargeCmd = 1'b0;
    logic [15:0] regRdData;
    logic wakePinIn, wakeSinkOn, sleeping, cpuResume, cpuClkEn;
    logic periphClkEn, hvRegNormal, hvRegStandby, lvRegOn, irqOut;
    logic [2:0] regs3;
    int failures = 0;
    int compares = 0;
    int w [5];
    assign regs3 = {hvRegNormal, hvRegStandby, lvRegOn};
    always #25 sys_clk = ~sys_clk;
    psc_power_saving_control #(.STANDBY_WAKE_CYC(4), .LV_WAKE_CYC(8)) uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .lvRegulatorConfig(lvRegulatorConfig),
        .sleepCmd(sleepCmd), .deepSleepCmd(deepSleepCmd), .idleMode(1'b0),
        .wakePinIn(wakePinIn), .cpuIrqReq(cpuIrqReq), .wakeSinkOn(wakeSinkOn),
        .sleeping(sleeping), .cpuResume(cpuResume), .cpuClkEn(cpuClkEn),
        .periphClkEn(periphClkEn), .hvRegNormal(hvRegNormal),
        .hvRegStandby(hvRegStandby), .lvRegOn(lvRegOn), .irqOut(irqOut)
    );
    psc_rc_model rc (.sys_clk(sys_clk), .chargeCmd(chargeCmd),
        .sinkOn(wakeSinkOn), .wakePin(wakePinIn));
    task automatic summarize;
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 chk(regRdData, exp);
    endtask : rd
    task automatic t_regs;
        logic [15:0] m [5];
        m = '{psc_pkg::WAKECON_MASK, psc_pkg::CLOCK_DIVIDER_REG_MASK,
            psc_pkg::PWRCTL_MASK, 16'h0000, psc_pkg::IRQ_MASK};
        for (int a = 0; a < 7; a++) begin
            rd(4'(a), (a == 5) ? 16'h0010 : 16'h0000);
        end
        for (int a = 0; a < 5; a++) begin
            wr(4'(a), 16'hFFFF);
            rd(4'(a), m[a]);
            wr(4'(a), 16'h0000);
        end
        wr(4'h6, 16'hFFFF);
        rd(4'h6, 16'h0000);
    endtask : t_regs
    task automatic t_doze;
        int n;
        for (int c = 0; c < 9; c++) begin
            wr(psc_pkg::OFF_CLOCK_DIVIDER_REG, {1'b0, 3'(c), c < 8, 11'h000});
            repeat (2) @(posedge sys_clk);
            n = 0;
            repeat (256) begin
                @(posedge sys_clk);
                #1 n += int'(cpuClkEn === 1'b1);
            end
            chk(16'(n), (c < 8) ? 16'(256 >> c) : 16'h0100);
        end
        wr(psc_pkg::OFF_CLOCK_DIVIDER_REG, 16'hB800);
        cpuIrqReq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(psc_pkg::OFF_CLOCK_DIVIDER_REG, 16'hB000);
        wr(psc_pkg::OFF_CLOCK_DIVIDER_REG, 16'h3800);
        rd(psc_pkg::OFF_CLOCK_DIVIDER_REG, 16'h3800);
        cpuIrqReq <= 1'b0;
        wr(psc_pkg::OFF_CLOCK_DIVIDER_REG, 16'h0000);
    endtask : t_doze
    task automatic t_sleep(input logic cfg, input logic [15:0] pwr,
            input logic [2:0] exp3, output int wt);
        @(posedge sys_clk);
        lvRegulatorConfig <= cfg;
        chargeCmd <= 1'b1;
        wr(psc_pkg::OFF_PWRCTL, pwr);
        chargeCmd <= 1'b0;
        wr(psc_pkg::OFF_WAKECON, 16'h8100);
        @(posedge sys_clk);
        sleepCmd <= 1'b1;
        @(posedge sys_clk);
        sleepCmd <= 1'b0;
        @(posedge sys_clk);
        #1 chk(16'(regs3), 16'(exp3));
        chk(16'(wakeSinkOn), 16'h0001);
        wt = 0;
        while (cpuResume !== 1'b1 && wt < 100) begin
            @(posedge sys_clk);
            #1 wt++;
        end
        chk(16'(cpuResume), 16'h0001);
        wt = 0;
        while (cpuClkEn !== 1'b1 && wt < 400) begin
            @(posedge sys_clk);
            #1 wt++;
        end
        rd(psc_pkg::OFF_IRQSTAT, 16'h0001);
        chk(16'(irqOut), 16'h0001);
        wr(psc_pkg::OFF_IRQMASK, 16'h0000);
        wr(psc_pkg::OFF_WAKECON, 16'h0000);
        #1 chk(16'(irqOut), 16'h0000);
        wr(psc_pkg::OFF_IRQMASK, 16'h0001);
        wr(psc_pkg::OFF_IRQSTAT, 16'h0001);
        rd(psc_pkg::OFF_IRQSTAT, 16'h0000);
        chk(16'(irqOut), 16'h0000);
    endtask : t_sleep
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_doze();
        wr(psc_pkg::OFF_IRQMASK, 16'h0001);
        t_sleep(1'b0, 16'h0100, 3'b100, w[0]);
        t_sleep(1'b0, 16'h0000, 3'b010, w[1]);
        t_sleep(1'b0, 16'h1000, 3'b001, w[2]);
        t_sleep(1'b1, 16'h1100, 3'b100, w[3]);
        t_sleep(1'b1, 16'h1000, 3'b010, w[4]);
        chk(16'(w[2] > w[1] && w[1] > w[0]), 16'h0001);
        @(posedge sys_clk);
        deepSleepCmd <= 1'b1;
        @(posedge sys_clk);
        deepSleepCmd <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(regs3), 16'h0000);
        summarize();
    end
    initial begin
        #1_000_000;
        failures++;
        summarize();
    end
endmodule : tb_top
bind psc_power_saving_control psc_assertions #(
    .STANDBY_WAKE_CYC(STANDBY_WAKE_CYC), .LV_WAKE_CYC(LV_WAKE_CYC)
) chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .lvRegulatorConfig(lvRegulatorConfig),
    .sleepCmd(sleepCmd), .deepSleepCmd(deepSleepCmd), .idleMode(idleMode),
    .wakePinIn(wakePinIn), .cpuIrqReq(cpuIrqReq), .wakeSinkOn(wakeSinkOn),
    .sleeping(sleeping), .cpuResume(cpuResume), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .hvRegNormal(hvRegNormal),
    .hvRegStandby(hvRegStandby), .lvRegOn(lvRegOn), .irqOut(irqOut)
);
